//--- verilog/iwd_top.sv
module iwd_top
    import iwd_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire iwd_bus_req_t bus_req,
    output logic [DATA_W-1:0] rdata,
    input wire logic low_speed_oscillator,
    input wire logic hw_watchdog_opt,
    input wire logic core_halted,
    input wire logic debug_freeze_bit,
    output logic watchdog_reset_request,
    output logic irq
);

    // Synchronisers for asynchronous pins
    logic osc_s1_r;
    logic osc_s2_r;
    logic osc_s3_r;
    logic opt_s1_r;
    logic opt_s2_r;
    logic tick;

    // Software-side state
    logic run_r;
    logic unlock_r;
    logic [2:0] div_sw_r;
    logic [CNT_W-1:0] rld_sw_r;
    logic [CNT_W-1:0] thr_sw_r;
    logic sel_r;

    // Oscillator-side working copies
    logic [2:0] div_act_r;
    logic [CNT_W-1:0] rld_act_r;
    logic [CNT_W-1:0] thr_act_r;
    logic [2:0] div_cnt_r;
    logic [2:0] rld_cnt_r;
    logic [2:0] thr_cnt_r;
    logic div_busy_r;
    logic rld_busy_r;
    logic thr_busy_r;
    logic upd_r;

    logic [PSC_W-1:0] psc_r;
    logic [CNT_W-1:0] cnt_r;
    logic [EV_W-1:0] ev_stat_r;
    logic [EV_W-1:0] ev_mask_r;
    logic [EV_W-1:0] ev_set;
    logic [DATA_W-1:0] rdata_r;
    logic rst_req_r;
    logic irq_r;

    logic key_wr;
    logic [15:0] key_val;
    logic wr_div;
    logic wr_rld;
    logic wr_thr;
    logic wr_ctl;
    logic step;
    logic frozen;

    // Prescaler terminal value for a division code; codes above six act as six
    // At code six the shift wraps to zero, so the limit lands on 255 as wanted
    function automatic logic [PSC_W-1:0] div_limit(input logic [2:0] code);
        logic [2:0] c;
        c = (code > DIV_CODE_MAX) ? DIV_CODE_MAX : code;
        div_limit = (DIV_BASE << c) - 8'h01;
    endfunction : div_limit

    // Register write strobe for one offset
    function automatic logic hit_wr(input iwd_bus_req_t r, input logic [ADDR_W-1:0] off);
        hit_wr = r.wr && (r.addr == off);
    endfunction : hit_wr

    // Oscillator edge detect; first stage feeds only the second
    always_ff @(posedge mclk)
    begin
        osc_s1_r <= low_speed_oscillator;
        osc_s2_r <= osc_s1_r;
        osc_s3_r <= osc_s2_r;
    end

    // Option strap is an outside level; two flops settle it before use
    always_ff @(posedge mclk)
    begin
        opt_s1_r <= hw_watchdog_opt;
        opt_s2_r <= opt_s1_r;
    end

    // Tick is one mclk wide; the oscillator must stay far below mclk/4
    // or edges are lost and the timeout stretches
    assign tick = osc_s2_r && !osc_s3_r;
    assign frozen = core_halted && debug_freeze_bit;


    // Key decode; only the low half of the word carries the code
    assign key_wr = hit_wr(bus_req, OFF_KEY);
    assign key_val = bus_req.wdata[15:0];
    // Guarded writes are also dropped while their busy flag is set so a transfer is never torn
    assign wr_div = hit_wr(bus_req, OFF_DIV) && unlock_r && !div_busy_r;
    assign wr_rld = hit_wr(bus_req, OFF_RLD) && unlock_r && !rld_busy_r;
    assign wr_thr = hit_wr(bus_req, OFF_THR) && unlock_r && !thr_busy_r;
    assign wr_ctl = hit_wr(bus_req, OFF_CTL);

    // Enable: start key or strapped hardware option; only reset stops it
    // There is no stop key, so a runaway program cannot switch it off
    always_ff @(posedge mclk)
    begin
        if (reset)
            run_r <= 1'b0;
        else if (opt_s2_r)
            run_r <= 1'b1;
        else if (key_wr && key_val == KEY_START)
            run_r <= 1'b1;
    end

    // Write protection follows the last key value
    // A stray key write relocks, so a half-done unlock is never left open
    always_ff @(posedge mclk)
    begin
        if (reset)
            unlock_r <= 1'b0;
        else if (key_wr)
            unlock_r <= (key_val == KEY_UNLOCK);
    end

    // Guarded configuration values as software sees them
    // Reads return these at once; counting sees them only when busy clears
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            div_sw_r <= DIV_RST;
            rld_sw_r <= CNT_FULL;
            thr_sw_r <= CNT_FULL;
        end
        else
        begin
            if (wr_div)
                div_sw_r <= bus_req.wdata[2:0];
            if (wr_rld)
                rld_sw_r <= bus_req.wdata[CNT_W-1:0];
            if (wr_thr)
                thr_sw_r <= bus_req.wdata[CNT_W-1:0];
        end
    end

    // Expiry action select; bit zero is guarded
    // The clear bit beside it is not guarded and is handled with the events
    always_ff @(posedge mclk)
    begin
        if (reset)
            sel_r <= 1'b0;
        else if (wr_ctl && unlock_r)
            sel_r <= bus_req.wdata[CTL_SEL_BIT];
    end

    // Busy flags: set by a write, cleared after a few oscillator ticks,
    // at which point the new value reaches the counting logic
    // Three ticks keep well inside the five-cycle limit software relies on
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            div_busy_r <= 1'b0;
            div_cnt_r <= BUSY_ZERO;
            div_act_r <= DIV_RST;
        end
        else if (wr_div)
        begin
            div_busy_r <= 1'b1;
            div_cnt_r <= BUSY_ZERO;
        end
        else if (div_busy_r && tick)
        begin
            div_cnt_r <= div_cnt_r + 3'h1;
            if (div_cnt_r + 3'h1 == BUSY_TICKS)
            begin
                div_busy_r <= 1'b0;
                div_act_r <= div_sw_r;
            end
        end
    end

    // Reload transfer; the old reload stays in use until busy clears
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rld_busy_r <= 1'b0;
            rld_cnt_r <= BUSY_ZERO;
            rld_act_r <= CNT_FULL;
        end
        else if (wr_rld)
        begin
            rld_busy_r <= 1'b1;
            rld_cnt_r <= BUSY_ZERO;
        end
        else if (rld_busy_r && tick)
        begin
            rld_cnt_r <= rld_cnt_r + 3'h1;
            if (rld_cnt_r + 3'h1 == BUSY_TICKS)
            begin
                rld_busy_r <= 1'b0;
                rld_act_r <= rld_sw_r;
            end
        end
    end

    // Threshold transfer, same scheme as the reload
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            thr_busy_r <= 1'b0;
            thr_cnt_r <= BUSY_ZERO;
            thr_act_r <= CNT_FULL;
        end
        else if (wr_thr)
        begin
            thr_busy_r <= 1'b1;
            thr_cnt_r <= BUSY_ZERO;
        end
        else if (thr_busy_r && tick)
        begin
            thr_cnt_r <= thr_cnt_r + 3'h1;
            if (thr_cnt_r + 3'h1 == BUSY_TICKS)
            begin
                thr_busy_r <= 1'b0;
                thr_act_r <= thr_sw_r;
            end
        end
    end

    // Refresh pending until the next tick loads the counter
    // Software can poll this to see that a refresh has really landed
    always_ff @(posedge mclk)
    begin
        if (reset)
            upd_r <= 1'b0;
        else if (key_wr && key_val == KEY_REFRESH)
            upd_r <= 1'b1;
        else if (tick)
            upd_r <= 1'b0;
    end

    // Prescaler: one counter step per divided oscillator period
    // Held at zero while stopped so a start always gives a full first period
    always_ff @(posedge mclk)
    begin
        if (reset || !run_r)
            psc_r <= '0;
        else if (tick && !frozen)
        begin
            if (psc_r >= div_limit(div_act_r))
                psc_r <= '0;
            else
                psc_r <= psc_r + 8'h01;
        end
    end

    assign step = run_r && tick && !frozen && (psc_r >= div_limit(div_act_r));

    // Down counter; a refresh takes precedence over a step in the same tick
    // In interrupt mode the expiry step reloads so counting carries on
    always_ff @(posedge mclk)
    begin
        if (reset)
            cnt_r <= CNT_FULL;
        else if (tick && upd_r)
            cnt_r <= rld_act_r;
        else if (step)
        begin
            if (cnt_r == CNT_ZERO)
                cnt_r <= rld_act_r;
            else
                cnt_r <= cnt_r - 12'h001;
        end
    end

    // Events raised by the counter this cycle
    // A load never raises the threshold event, only a decrement onto it
    always_comb
    begin
        ev_set = EV_NONE;
        if (step && !(tick && upd_r))
        begin
            if (cnt_r != CNT_ZERO && cnt_r - 12'h001 == thr_act_r)
                ev_set[EV_THR_BIT] = 1'b1;
            if (cnt_r == CNT_ZERO && sel_r)
                ev_set[EV_EXP_BIT] = 1'b1;
        end
    end

    // Reset request holds until the system reset comes back
    // Holding it means a short reset pulse elsewhere cannot be missed
    always_ff @(posedge mclk)
    begin
        if (reset)
            rst_req_r <= 1'b0;
        else if (step && !(tick && upd_r) && cnt_r == CNT_ZERO && !sel_r)
            rst_req_r <= 1'b1;
    end

    // Sticky events: read or clear bit clears, a new event wins
    always_ff @(posedge mclk)
    begin
        if (reset)
            ev_stat_r <= EV_NONE;
        else if ((bus_req.rd && bus_req.addr == OFF_EVS)
                 || (wr_ctl && bus_req.wdata[CTL_CLR_BIT]))
            ev_stat_r <= ev_set;
        else
            ev_stat_r <= ev_stat_r | ev_set;
    end

    // Event mask, free to write; it only gates the interrupt output
    always_ff @(posedge mclk)
    begin
        if (reset)
            ev_mask_r <= EV_NONE;
        else if (hit_wr(bus_req, OFF_EVM))
            ev_mask_r <= bus_req.wdata[EV_W-1:0];
    end

    // Level interrupt, one cycle behind the status
    // The lag buys a clean flop output with no decode glitches
    always_ff @(posedge mclk)
    begin
        if (reset)
            irq_r <= 1'b0;
        else
            irq_r <= |(ev_stat_r & ev_mask_r);
    end

    // Read data, valid in the cycle after the read strobe only
    // Returning zero otherwise lets several slaves share an or-ed read bus
    always_ff @(posedge mclk)
    begin
        if (reset || !bus_req.rd)
            rdata_r <= '0;
        else
        begin
            rdata_r <= '0;
            case (bus_req.addr)
                OFF_DIV: rdata_r[2:0] <= div_sw_r;
                OFF_RLD: rdata_r[CNT_W-1:0] <= rld_sw_r;
                OFF_UST:
                begin
                    rdata_r[UST_DIV_BIT] <= div_busy_r;
                    rdata_r[UST_RLD_BIT] <= rld_busy_r;
                    rdata_r[UST_THR_BIT] <= thr_busy_r;
                    rdata_r[UST_UPD_BIT] <= upd_r;
                end
                OFF_CTL: rdata_r[CTL_SEL_BIT] <= sel_r;
                OFF_THR: rdata_r[CNT_W-1:0] <= thr_sw_r;
                OFF_CNT: rdata_r[CNT_W-1:0] <= cnt_r;
                OFF_EVS: rdata_r[EV_W-1:0] <= ev_stat_r;
                OFF_EVM: rdata_r[EV_W-1:0] <= ev_mask_r;
                default: rdata_r <= '0;
            endcase
        end
    end

    // Outputs straight from their flops
    assign rdata = rdata_r;
    assign watchdog_reset_request = rst_req_r;
    assign irq = irq_r;

endmodule : iwd_top

//--- verilog/iwd_pkg.sv
// Summary of operation
// - Start code enables watchdog, counting from full
// - Counter reaching zero requests system reset
// - Refresh code reloads counter from reload register
// - Unlock code opens guarded configuration registers
// - Any other key value relocks them
// - Refresh code also relocks them
// - Hardware option starts watchdog after reset
// - Debug halt freezes counter when bit set
// - Counter advances only on oscillator ticks
// - Timeout is divider times reload plus one
// - Update flag clears when reload reaches counter
// - Threshold busy clears within five oscillator cycles
// - Reload busy clears within five oscillator cycles
// - Divider busy clears within five oscillator cycles
// - Control bit selects interrupt instead of reset
// - Writing one clears pending interrupt, no unlock
// - Counter reaching threshold raises an interrupt
package iwd_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 12;
    localparam int PSC_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_KEY = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DIV = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RLD = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_UST = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CTL = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_THR = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_CNT = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_EVS = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_EVM = 8'h20;

    // Key codes
    localparam logic [15:0] KEY_START = 16'hCCCC;
    localparam logic [15:0] KEY_REFRESH = 16'hAAAA;
    localparam logic [15:0] KEY_UNLOCK = 16'h5555;

    // Reset values and field positions
    localparam logic [CNT_W-1:0] CNT_FULL = 12'hFFF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam int CTL_SEL_BIT = 0;
    localparam int CTL_CLR_BIT = 1;
    localparam int UST_DIV_BIT = 0;
    localparam int UST_RLD_BIT = 1;
    localparam int UST_THR_BIT = 2;
    localparam int UST_UPD_BIT = 3;
    localparam int EV_W = 2;
    localparam int EV_THR_BIT = 0;
    localparam int EV_EXP_BIT = 1;
    localparam logic [EV_W-1:0] EV_NONE = 2'h0;

    // Oscillator ticks a busy flag stays set; must be at most five
    localparam logic [2:0] BUSY_TICKS = 3'h3;
    localparam logic [2:0] BUSY_ZERO = 3'h0;
    localparam logic [PSC_W-1:0] DIV_BASE = 8'h04;
    localparam logic [2:0] DIV_CODE_MAX = 3'h6;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } iwd_bus_req_t;

endpackage : iwd_pkg

//--- sim/iwd_top_props.sv
module iwd_top_props
    import iwd_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire iwd_bus_req_t bus_req,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic low_speed_oscillator,
    input wire logic hw_watchdog_opt,
    input wire logic core_halted,
    input wire logic debug_freeze_bit,
    input wire logic watchdog_reset_request,
    input wire logic irq
);
    // Debug freeze; no counter step can happen while it holds
    wire logic frz = core_halted && debug_freeze_bit;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Reset request holds until the next reset
    req_sticky_a: assert property (watchdog_reset_request |=> watchdog_reset_request)
        else $error("reset request dropped");
    freeze_hold_a: assert property (frz && $past(frz) |-> !$rose(watchdog_reset_request))
        else $error("expiry while frozen");
    // Pending clears are checked only under freeze, where no new event can win
    ctl_clear_a: assert property (
        bus_req.wr && bus_req.addr == OFF_CTL && bus_req.wdata[CTL_CLR_BIT] && frz ##1 frz
        |-> ##1 !irq) else $error("clear bit left irq high");
    evs_clear_a: assert property (
        bus_req.rd && bus_req.addr == OFF_EVS && frz ##1 frz |-> ##1 !irq)
        else $error("status read left irq high");
    // Unused upper bits of readback words stay zero
    status_rsv_a: assert property (
        $past(bus_req.rd) && $past(bus_req.addr) == OFF_UST |-> rdata[31:4] == '0)
        else $error("status upper bits set");
    count_rsv_a: assert property (
        $past(bus_req.rd) && $past(bus_req.addr) == OFF_CNT |-> rdata[31:12] == '0)
        else $error("counter upper bits set");
    div_rsv_a: assert property (
        $past(bus_req.rd) && $past(bus_req.addr) == OFF_DIV |-> rdata[31:3] == '0)
        else $error("divider upper bits set");
    thr_rsv_a: assert property (
        $past(bus_req.rd) && $past(bus_req.addr) == OFF_THR |-> rdata[31:12] == '0)
        else $error("threshold upper bits set");
endmodule : iwd_top_props

bind iwd_top iwd_top_props i_props (.mclk, .reset, .bus_req, .rdata, .low_speed_oscillator,
    .hw_watchdog_opt, .core_halted, .debug_freeze_bit, .watchdog_reset_request, .irq);

//--- sim/iwd_top_tb.sv
module iwd_top_tb
    import iwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset, low_speed_oscillator, hw_watchdog_opt, core_halted, debug_freeze_bit;
    logic watchdog_reset_request, irq, osc_run;
    iwd_bus_req_t bus_req;
    logic [DATA_W-1:0] rdata, last, v;
    logic [2:0] ocnt;
    int error_cnt, cmp_count, cyc, ticks;
    logic [7:0] ra [8] = '{OFF_DIV, OFF_RLD, OFF_UST, OFF_CTL, OFF_THR, OFF_CNT, OFF_EVS, 8'h24};
    logic [31:0] rv [8] = '{32'h0, 32'hFFF, 32'h0, 32'h0, 32'hFFF, 32'hFFF, 32'h0, 32'h0};

    iwd_top i_dut (.mclk, .reset, .bus_req, .rdata, .low_speed_oscillator, .hw_watchdog_opt,
        .core_halted, .debug_freeze_bit, .watchdog_reset_request, .irq);

    always #4 mclk = ~mclk;

    // Slow tick source, eight mclk a period; stopping it shows the counter needs ticks
    always @(posedge mclk)
    begin
        if (osc_run) ocnt <= ocnt + 3'h1;
        low_speed_oscillator <= ocnt[2];
    end
    always @(posedge low_speed_oscillator) ticks++;

    // Hang guard, well above the longest expected run
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk

    // Strobes last one cycle; the idle cycle after each keeps drivers single per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
    endtask : wr

    task automatic get(input logic [7:0] a);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge mclk);
        bus_req <= '0;
        @(negedge mclk) last = rdata;
        @(posedge mclk);
    endtask : get

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        get(a);
        chk(last, e, "read data");
    endtask : rd

    // Bounded wait for irq or the reset request
    task automatic hold_for(input logic use_irq);
        int n;
        n = 0;
        while ((use_irq ? irq : watchdog_reset_request) !== 1'b1 && n < 3000)
        begin
            @(negedge mclk);
            n++;
        end
        chk(32'(use_irq ? irq : watchdog_reset_request), 32'h1, "event missing");
        @(posedge mclk);
    endtask : hold_for

    initial
    begin
        reset = 1'b1;
        bus_req = '0;
        {low_speed_oscillator, hw_watchdog_opt, core_halted, debug_freeze_bit} = 4'h0;
        ocnt = 3'h0;
        osc_run = 1'b1;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        foreach (ra[i]) rd(ra[i], rv[i]);
        wr(OFF_RLD, 32'h00F);
        rd(OFF_RLD, 32'hFFF);
        wr(OFF_KEY, 32'h5555);
        wr(OFF_DIV, 32'h1);
        wr(OFF_RLD, 32'h00F);
        wr(OFF_THR, 32'h008);
        wr(OFF_CTL, 32'h1);
        rd(OFF_UST, 32'h7);
        repeat (48) @(posedge mclk);
        rd(OFF_UST, 32'h0);
        wr(OFF_KEY, 32'h1234);
        wr(OFF_RLD, 32'h0AA);
        rd(OFF_RLD, 32'h00F);
        wr(OFF_EVM, 32'h2);
        osc_run <= 1'b0;
        wr(OFF_KEY, 32'hCCCC);
        rd(OFF_CNT, 32'hFFF);
        wr(OFF_KEY, 32'h5555);
        wr(OFF_KEY, 32'hAAAA);
        rd(OFF_UST, 32'h8);
        rd(OFF_CNT, 32'hFFF);
        wr(OFF_RLD, 32'h0AA);
        rd(OFF_RLD, 32'h00F);
        ticks = 0;
        osc_run <= 1'b1;
        repeat (24) @(posedge mclk);
        rd(OFF_UST, 32'h0);
        rd(OFF_CNT, 32'h00F);
        // Threshold event is masked, so the first irq is the expiry
        hold_for(1'b1);
        chk(32'(ticks >= 128 && ticks <= 130), 32'h1, "timeout length");
        chk(32'(watchdog_reset_request), 32'h0, "reset in irq mode");
        rd(OFF_EVS, 32'h3);
        wr(OFF_EVM, 32'h3);
        hold_for(1'b1);
        core_halted <= 1'b1;
        debug_freeze_bit <= 1'b1;
        @(posedge mclk);
        wr(OFF_CTL, 32'h2);
        rd(OFF_EVS, 32'h0);
        get(OFF_CNT);
        v = last;
        repeat (100) @(posedge mclk);
        get(OFF_CNT);
        chk(last, v, "frozen count moved");
        debug_freeze_bit <= 1'b0;
        repeat (100) @(posedge mclk);
        get(OFF_CNT);
        chk(32'(last !== v), 32'h1, "halted count stuck");
        core_halted <= 1'b0;
        wr(OFF_KEY, 32'h5555);
        wr(OFF_CTL, 32'h0);
        wr(OFF_KEY, 32'hAAAA);
        hold_for(1'b0);
        hw_watchdog_opt <= 1'b1;
        reset <= 1'b1;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        repeat (100) @(posedge mclk);
        chk(32'(watchdog_reset_request), 32'h0, "request after reset");
        get(OFF_CNT);
        chk(32'(last < 32'hFFF), 32'h1, "no automatic start");
        stop_test();
    end
endmodule : iwd_top_tb
